// *** src/tbu_pkg.sv ***
// Purpose: shared constants for the timer time base unit
// Assumes: byte wide registers, each in the low lane of one aligned word
// Notes: offsets are byte addresses on the register bus
package tbu_pkg;
  // register bus address width
  localparam int TBU_AW = 8;
  // register offsets
  localparam logic [7:0] TBU_OFS_CTRL = 8'h00;
  localparam logic [7:0] TBU_OFS_STAT = 8'h04;
  localparam logic [7:0] TBU_OFS_EVGEN = 8'h08;
  localparam logic [7:0] TBU_OFS_CNTH = 8'h0C;
  localparam logic [7:0] TBU_OFS_CNTL = 8'h10;
  localparam logic [7:0] TBU_OFS_DIVH = 8'h14;
  localparam logic [7:0] TBU_OFS_DIVL = 8'h18;
  localparam logic [7:0] TBU_OFS_RLDH = 8'h1C;
  localparam logic [7:0] TBU_OFS_RLDL = 8'h20;
  // control_reg_one fields
  localparam int TBU_CTRL_EN = 0;
  localparam int TBU_CTRL_UPDATE_DISABLE = 1;
  localparam int TBU_CTRL_URS = 2;
  localparam int TBU_CTRL_DOWN = 4;
  localparam int TBU_CTRL_RELOAD_PRELOAD_ENABLE = 7;
  // status_reg_one and event_generation_reg fields
  localparam int TBU_STAT_UPD = 0;
  localparam int TBU_EVGEN_UG = 0;
  // reset values
  localparam logic [15:0] TBU_CNT_RST = 16'h0000;
  localparam logic [15:0] TBU_RLD_RST = 16'h0000;
  localparam logic [15:0] TBU_DIV_RST = 16'h0000;
  // bus responses
  localparam logic [1:0] TBU_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBU_RESP_SLVERR = 2'h2;
endpackage

// *** src/tbu_psc_if.sv ***
// Purpose: link between the time base core and its prescaler
// Assumes: single clock, all signals sampled on mclk_i
// Notes: tick is a one-cycle pulse per divided counter clock
`timescale 1ns/100ps
interface tbu_psc_if;
  logic run;
  logic restart;
  logic load;
  logic [15:0] div;
  logic tick;
  modport psc (input run, input restart, input load, input div,
    output tick);
  modport ctl (output run, output restart, output load, output div,
    input tick);
endinterface

// *** src/tbu_sync.sv ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: input asynchronous to mclk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module tbu_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // pin side and synchronised side
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic meta;
    logic stable;
  } tbu_sync_s;

  tbu_sync_s q, d;

  // shift the pin through two stages
  always_comb begin
    d = q;
    d.meta = pin_i;
    d.stable = q.meta;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.stable;
endmodule

// *** src/tbu_prescaler.sv ***
// Purpose: 16-bit prescaler producing the counter clock enable
// Assumes: divider preload handed over by the core
// Notes: working divider changes only on load, ratio is div plus one
`timescale 1ns/100ps
module tbu_prescaler (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // link to the core
  tbu_psc_if.psc psc
);
  import tbu_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] div;
    logic tick;
  } tbu_psc_s;

  tbu_psc_s q, d;

  // divide by div+1 while running, restart keeps the ratio
  // a divider loaded this cycle already sets the limit, so the old
  // ratio cannot leak one extra tick past the update
  always_comb begin
    logic [15:0] lim;
    lim = psc.load ? psc.div : q.div;
    d = q;
    d.tick = 1'b0;
    if (psc.restart) begin
      d.cnt = 16'h0000;
    end else if (psc.run) begin
      if (q.cnt == lim) begin
        d.cnt = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
    // working divider follows the preload only on an update
    if (psc.load) begin
      d.div = psc.div;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign psc.tick = q.tick;
endmodule

// *** src/tbu_top.sv ***
// Purpose: time base unit of a 16-bit timer with AXI4-Lite registers
// Assumes: one clock mclk_i, asynchronous active high reset rst_i
// Notes: byte registers sit in the low lane, upper bits read zero
`timescale 1ns/100ps
module tbu_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tbu_pkg::TBU_AW-1:0] s_axi_awaddr,
  // write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [tbu_pkg::TBU_AW-1:0] s_axi_araddr,
  // read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // trigger from the clock/trigger controller, asynchronous pin
  input wire logic trig_i,
  // timer status
  output logic [15:0] count_o,
  output logic counter_run_signal_o,
  output logic update_event_o,
  output logic overflow_o,
  output logic update_flag_o
);
  import tbu_pkg::*;

  typedef enum logic {
    TBU_RD_IDLE = 1'b0,
    TBU_RD_RESP = 1'b1
  } tbu_rd_e;

  typedef struct packed {
    // bus slave
    logic aw_ok;
    logic w_ok;
    logic [TBU_AW-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    tbu_rd_e rstate;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // control_reg_one
    logic en;
    logic update_disable;
    logic update_request_source;
    logic down;
    logic reload_preload_enable;
    // time base state
    logic run;
    logic flag;
    logic [15:0] cnt;
    logic [15:0] rld_pre;
    logic [15:0] rld_sh;
    logic rld_lock;
    logic [15:0] div_pre;
    logic [7:0] div_hi;
    logic [7:0] cnt_buf;
    logic buf_hold;
    logic trig_last;
    logic update_event;
    logic ovf;
  } tbu_top_s;

  tbu_top_s q, d;
  tbu_psc_if psc_link ();
  logic trig_lvl;
  logic psc_run;
  logic psc_restart;
  logic psc_load;
  logic [15:0] psc_div;

  //////////////////////////////////////////////////////////////////////
  // submodules

  // trigger pin is asynchronous, so it is synchronised first
  tbu_sync u_trig_sync (
    .mclk_i (mclk_i),
    .rst_i (rst_i),
    .pin_i (trig_i),
    .level_o (trig_lvl)
  );

  tbu_prescaler u_psc (
    .mclk_i (mclk_i),
    .rst_i (rst_i),
    .psc (psc_link.psc)
  );

  assign psc_link.run = psc_run;
  assign psc_link.restart = psc_restart;
  assign psc_link.load = psc_load;
  assign psc_link.div = psc_div;

  //////////////////////////////////////////////////////////////////////
  // address decode helper

  function automatic logic tbu_mapped(input logic [TBU_AW-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      TBU_OFS_CTRL, TBU_OFS_STAT, TBU_OFS_EVGEN, TBU_OFS_CNTH,
      TBU_OFS_CNTL, TBU_OFS_DIVH, TBU_OFS_DIVL, TBU_OFS_RLDH,
      TBU_OFS_RLDL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic do_wr;
    logic do_rd;
    logic [TBU_AW-1:0] wa;
    logic [7:0] wb;
    logic wlane;
    logic [7:0] rb;
    logic ug;
    logic trig;
    logic wrap;
    logic update_event;
    logic step;
    logic [15:0] rld_now;
    do_wr = 1'b0;
    do_rd = 1'b0;
    wa = '0;
    wb = 8'h00;
    wlane = 1'b0;
    rb = 8'h00;
    ug = 1'b0;
    trig = 1'b0;
    wrap = 1'b0;
    update_event = 1'b0;
    step = 1'b0;
    rld_now = 16'h0000;
    d = q;
    d.update_event = 1'b0;
    d.ovf = 1'b0;

    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_ok = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_ok = 1'b1;
      d.wbyte = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0];
    end
    if (d.aw_ok && d.w_ok && !q.bvalid) begin
      do_wr = 1'b1;
      wa = d.awaddr;
      wb = d.wbyte;
      wlane = d.wlane;
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = tbu_mapped(wa) ? TBU_RESP_OKAY : TBU_RESP_SLVERR;
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // a byte write with lane 0 off stores nothing
    do_wr = do_wr && wlane;

    // read channel: one read in flight, data sampled at acceptance
    do_rd = s_axi_arvalid && q.arready;
    case (q.rstate)
      TBU_RD_IDLE: begin
        if (do_rd) begin
          d.rstate = TBU_RD_RESP;
        end
      end
      TBU_RD_RESP: begin
        if (s_axi_rready) begin
          d.rstate = TBU_RD_IDLE;
        end
      end
      default: d.rstate = TBU_RD_IDLE;
    endcase

    // read mux, upper bits of every register read as zero
    case (s_axi_araddr)
      TBU_OFS_CTRL: rb = {q.reload_preload_enable, 2'b00, q.down, 1'b0, q.update_request_source, q.update_disable,
        q.en};
      TBU_OFS_STAT: rb = {7'h00, q.flag};
      TBU_OFS_CNTH: rb = q.cnt[15:8];
      TBU_OFS_CNTL: rb = q.buf_hold ? q.cnt_buf : q.cnt[7:0];
      TBU_OFS_DIVH: rb = q.div_pre[15:8];
      TBU_OFS_DIVL: rb = q.div_pre[7:0];
      TBU_OFS_RLDH: rb = q.rld_pre[15:8];
      TBU_OFS_RLDL: rb = q.rld_pre[7:0];
      default: rb = 8'h00;
    endcase
    if (do_rd) begin
      d.rdata = {24'h000000, rb};
      d.rresp = tbu_mapped(s_axi_araddr) ? TBU_RESP_OKAY
        : TBU_RESP_SLVERR;
      // high byte read freezes the low byte until it is read
      if (s_axi_araddr == TBU_OFS_CNTH) begin
        d.cnt_buf = q.cnt[7:0];
        d.buf_hold = 1'b1;
      end else if (s_axi_araddr == TBU_OFS_CNTL) begin
        d.buf_hold = 1'b0;
      end
    end

    // event sources
    ug = do_wr && (wa == TBU_OFS_EVGEN) && wb[TBU_EVGEN_UG];
    trig = trig_lvl && !q.trig_last;
    d.trig_last = trig_lvl;
    step = q.run && psc_link.tick;
    if (q.down) begin
      wrap = step && (q.cnt == 16'h0000);
    end else begin
      wrap = step && (q.cnt == q.rld_sh);
    end
    update_event = !q.update_disable && (wrap || ug || trig);

    // shadow first so a down reload already sees the new limit
    if (update_event && !q.rld_lock) begin
      d.rld_sh = q.rld_pre;
    end
    rld_now = d.rld_sh;

    // counting continues whether or not updates are allowed
    if (step) begin
      if (q.down) begin
        d.cnt = wrap ? rld_now : q.cnt - 16'h0001;
      end else begin
        d.cnt = wrap ? 16'h0000 : q.cnt + 16'h0001;
      end
      d.ovf = wrap;
    end
    // forced update restarts the count from its starting point
    if (update_event && (ug || trig)) begin
      d.cnt = q.down ? rld_now : 16'h0000;
    end

    // flag clears on a written zero, a new update wins the clash
    if (do_wr && (wa == TBU_OFS_STAT) && !wb[TBU_STAT_UPD]) begin
      d.flag = 1'b0;
    end
    if (update_event && (wrap || trig || !q.update_request_source)) begin
      d.flag = 1'b1;
    end
    d.update_event = update_event;

    // register writes
    if (do_wr) begin
      case (wa)
        TBU_OFS_CTRL: begin
          d.en = wb[TBU_CTRL_EN];
          d.update_disable = wb[TBU_CTRL_UPDATE_DISABLE];
          d.update_request_source = wb[TBU_CTRL_URS];
          d.down = wb[TBU_CTRL_DOWN];
          d.reload_preload_enable = wb[TBU_CTRL_RELOAD_PRELOAD_ENABLE];
        end
        TBU_OFS_CNTH: d.cnt[15:8] = wb;
        TBU_OFS_CNTL: d.cnt[7:0] = wb;
        TBU_OFS_DIVH: d.div_hi = wb;
        TBU_OFS_DIVL: d.div_pre = {q.div_hi, wb};
        TBU_OFS_RLDH: begin
          d.rld_pre[15:8] = wb;
          d.rld_lock = 1'b1;
        end
        TBU_OFS_RLDL: begin
          d.rld_pre[7:0] = wb;
          d.rld_lock = 1'b0;
          if (!q.reload_preload_enable) begin
            d.rld_sh = {q.rld_pre[15:8], wb};
          end
        end
        default: d.rld_lock = q.rld_lock;
      endcase
    end

    // enable reaches the counter one clock later
    d.run = q.en;

    // ready flags are registered so the bus sees flop outputs
    d.awready = !d.aw_ok && !d.bvalid;
    d.wready = !d.w_ok && !d.bvalid;
    d.arready = (d.rstate == TBU_RD_IDLE);

    // prescaler control
    psc_run = q.run;
    psc_restart = update_event && (ug || trig);
    psc_load = update_event;
    psc_div = q.div_pre;
  end

  //////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.rstate <= TBU_RD_IDLE;
      q.cnt <= TBU_CNT_RST;
      q.rld_pre <= TBU_RLD_RST;
      q.rld_sh <= TBU_RLD_RST;
      q.div_pre <= TBU_DIV_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = (q.rstate == TBU_RD_RESP);
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign count_o = q.cnt;
  assign counter_run_signal_o = q.run;
  assign update_event_o = q.update_event;
  assign overflow_o = q.ovf;
  assign update_flag_o = q.flag;
endmodule

// *** test/tbu_top_sva.sv ***
// Purpose: port level checks for the time base unit
// Assumes: one clock, asynchronous active high reset
// Notes: bus write and trigger activity mutes the counter checks
`timescale 1ns/100ps
module tbu_top_sva (
  // clock and reset
  input logic mclk_i,
  input logic rst_i,
  // register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // timer side
  input logic trig_i,
  input logic [15:0] count_o,
  input logic counter_run_signal_o,
  input logic overflow_o,
  input logic update_event_o,
  input logic update_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic trig_q;
  logic [3:0] quiet_q;
////////////////////////////////////////
  // cycles since the last bus write or trigger edge, saturating
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      trig_q <= trig_i;
      if (s_axi_awvalid || s_axi_wvalid || trig_i != trig_q)
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
        quiet_q <= quiet_q + 4'h1;
    end
  end
////////////////////////////////////////
  // counter stopped and idle after reset release
  a_reset_idle: assert property ($fell(rst_i) |->
    count_o == 16'h0000 && !counter_run_signal_o)
    else $error("counter not idle after reset");
  // a stopped counter only moves on a write or trigger
  a_stop_hold: assert property ((!counter_run_signal_o)[*3] ##0
    (quiet_q > 4'h8 && !s_axi_awvalid && !s_axi_wvalid)
    |=> $stable(count_o)) else $error("stopped counter moved");
  // run rises one clock after the enable write lands
  a_run_delay: assert property ($rose(counter_run_signal_o) |->
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("run not one cycle after enable");
  // free running count moves by one or wraps
  a_step_size: assert property (counter_run_signal_o &&
    quiet_q > 4'h8 && $changed(count_o) |->
    count_o == $past(count_o) + 16'h0001 ||
    count_o == $past(count_o) - 16'h0001 ||
    count_o == 16'h0000 || overflow_o || $past(overflow_o))
    else $error("counter jumped");
  // read answers come exactly one cycle after the request
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("late read answer");
  a_wr_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready during resp");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write response repeated");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read response repeated");
  a_rdata_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper data set");
  // main scenarios
  cover property (overflow_o);
  cover property (update_event_o);
  cover property ($rose(update_flag_o));
endmodule
bind tbu_top tbu_top_sva u_tbu_top_sva (.*);

// *** test/tbu_top_bench.sv ***
// Purpose: self checking bench for the time base unit
// Assumes: byte registers in the low lane of each word
// Notes: periods are measured between two wrap pulses
`timescale 1ns/100ps
module tbu_top_bench;
  import tbu_pkg::*;
  localparam logic [7:0] C_EN = 8'h01 << TBU_CTRL_EN;
  localparam logic [7:0] C_UPDATE_DISABLE = 8'h01 << TBU_CTRL_UPDATE_DISABLE;
  localparam logic [7:0] C_URS = 8'h01 << TBU_CTRL_URS;
  localparam logic [7:0] C_DOWN = 8'h01 << TBU_CTRL_DOWN;
  localparam logic [7:0] C_RELOAD_PRELOAD_ENABLE = 8'h01 << TBU_CTRL_RELOAD_PRELOAD_ENABLE;
  logic mclk_i, rst_i, trig_i, hit;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic counter_run_signal_o, update_event_o, overflow_o, update_flag_o;
  logic [TBU_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] count_o;
  int err_count, compares, uev_cnt;

  tbu_top u_tbu_top (.*);
////////////////////////////////////////
  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // update pulses seen, so a task can count events across a window
  always @(posedge mclk_i) begin
    if (update_event_o === 1'b1) uev_cnt <= uev_cnt + 1;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // bus write; settles three cycles so event effects have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) begin
      err_count++;
      end_of_test();
    end
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      err_count++;
      end_of_test();
    end
  endtask

  // cycles from one wrap pulse to the next
  task automatic per(input int e);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk_i);
        n++;
      end while (!overflow_o && n < 300);
      // no wrap at all counts as a mismatch and ends the run
      if (n >= 300) begin
        err_count++;
        end_of_test();
      end
    end
    chk(n, e);
  endtask

  task automatic seek(input logic [15:0] v);
    hit = 1'b0;
    repeat (40) begin
      @(posedge mclk_i);
      if (count_o === v) hit = 1'b1;
    end
  endtask
////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4));
      chk(rdat, 0);
      chk(resp, TBU_RESP_OKAY);
    end
    chk(counter_run_signal_o, 0);
    $display("reset test done");
  endtask

  task automatic t_up();
    wr(TBU_OFS_DIVL, 8'h01);
    wr(TBU_OFS_RLDL, 8'h05);
    wr(TBU_OFS_EVGEN, 8'h01);
    chk(update_flag_o, 1);
    chk(count_o, 0);
    wr(TBU_OFS_STAT, 8'h00);
    wr(TBU_OFS_DIVL, 8'h03);
    rd(TBU_OFS_DIVL);
    chk(rdat, 3);
    wr(TBU_OFS_DIVL, 8'h01);
    wr(TBU_OFS_CTRL, C_EN);
    chk(counter_run_signal_o, 1);
    per(12);
    chk(update_flag_o, 1);
    wr(TBU_OFS_DIVL, 8'h03);
    per(24);
    wr(TBU_OFS_DIVL, 8'h01);
    $display("up test done");
  endtask

  task automatic t_preload();
    wr(TBU_OFS_CTRL, C_RELOAD_PRELOAD_ENABLE);
    wr(TBU_OFS_EVGEN, 8'h01);
    wr(TBU_OFS_RLDL, 8'h03);
    wr(TBU_OFS_CTRL, C_EN | C_RELOAD_PRELOAD_ENABLE);
    seek(16'h0005);
    chk(hit, 1);
    per(8);
    $display("preload test done");
  endtask

  task automatic t_down();
    wr(TBU_OFS_CTRL, C_RELOAD_PRELOAD_ENABLE | C_DOWN);
    wr(TBU_OFS_RLDL, 8'h04);
    wr(TBU_OFS_EVGEN, 8'h01);
    chk(count_o, 4);
    wr(TBU_OFS_CTRL, C_EN | C_RELOAD_PRELOAD_ENABLE | C_DOWN);
    per(10);
    $display("down test done");
  endtask

  task automatic t_disable();
    int n0;
    wr(TBU_OFS_CTRL, C_EN | C_RELOAD_PRELOAD_ENABLE | C_DOWN | C_UPDATE_DISABLE);
    n0 = uev_cnt;
    wr(TBU_OFS_RLDL, 8'h02);
    wr(TBU_OFS_STAT, 8'h00);
    wr(TBU_OFS_EVGEN, 8'h01);
    seek(16'h0004);
    chk(hit, 1);
    chk(update_flag_o, 0);
    chk(uev_cnt - n0, 0);
    wr(TBU_OFS_CTRL, C_EN | C_RELOAD_PRELOAD_ENABLE | C_DOWN);
    per(6);
    $display("disable test done");
  endtask

  task automatic t_source();
    int n0;
    wr(TBU_OFS_CTRL, C_URS);
    wr(TBU_OFS_CNTL, 8'h09);
    wr(TBU_OFS_STAT, 8'h00);
    n0 = uev_cnt;
    wr(TBU_OFS_EVGEN, 8'h01);
    chk(uev_cnt - n0, 1);
    chk(update_flag_o, 0);
    chk(count_o, 0);
    $display("source test done");
  endtask

  task automatic t_trigger();
    wr(TBU_OFS_CTRL, 8'h00);
    wr(TBU_OFS_CNTL, 8'h07);
    @(posedge mclk_i);
    trig_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    trig_i <= 1'b0;
    chk(count_o, 0);
    chk(update_flag_o, 1);
    $display("trigger test done");
  endtask

  task automatic t_counter();
    wr(TBU_OFS_CNTH, 8'hAB);
    wr(TBU_OFS_CNTL, 8'hCD);
    chk(count_o, 16'hABCD);
    rd(TBU_OFS_CNTH);
    chk(rdat, 8'hAB);
    wr(TBU_OFS_CNTL, 8'h11);
    rd(TBU_OFS_CNTL);
    chk(rdat, 8'hCD);
    rd(TBU_OFS_CNTL);
    chk(rdat, 8'h11);
    // lane 0 strobe off: the write is answered but stores nothing
    s_axi_wstrb <= 4'h0;
    wr(TBU_OFS_CNTL, 8'h55);
    chk(resp, TBU_RESP_OKAY);
    chk(count_o, 16'hAB11);
    s_axi_wstrb <= 4'hF;
    wr(8'h24, 8'hFF);
    chk(resp, TBU_RESP_SLVERR);
    rd(8'h24);
    chk(resp, TBU_RESP_SLVERR);
    chk(rdat, 0);
    $display("counter test done");
  endtask

  // high byte alone must not reach the shadow on an update
  task automatic t_blocked();
    wr(TBU_OFS_CTRL, C_RELOAD_PRELOAD_ENABLE);
    wr(TBU_OFS_RLDH, 8'h01);
    wr(TBU_OFS_EVGEN, 8'h01);
    wr(TBU_OFS_CTRL, C_EN | C_RELOAD_PRELOAD_ENABLE);
    per(6);
    $display("blocked test done");
  endtask
////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    compares = 0;
    rst_i <= 1'b1;
    trig_i <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'hF;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_up();
    t_preload();
    t_down();
    t_disable();
    t_source();
    t_trigger();
    t_counter();
    t_blocked();
    // second reset while the counter runs and the flag is set
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    end_of_test();
  end
endmodule
